// ---- hpd_dma_model.sv ----
/*
  Behavioural DMA controller that answers the host port's request pairs.
  Assumes requests are registered on clk and that the bench owns the stall input.
*/
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module hpd_dma_model (
  input wire logic clk,
  input wire logic [1:0] dreq_n,
  input wire logic stall,
  output logic [1:0] dack_n,
  output logic [7:0] dat,
  output logic drv
);
  logic [7:0] nxt;

  // One byte per acknowledge, read pair served first; stall withholds every acknowledge.
  initial begin
    dack_n = 2'h3;
    drv = 1'b0;
    dat = 8'h00;
    nxt = 8'ha0;
    forever begin
      @(negedge clk);
      if (!stall && dreq_n[1] === 1'b0) begin
        dack_n[1] = 1'b0;
        repeat (5) @(negedge clk);
        dack_n[1] = 1'b1;
        repeat (4) @(negedge clk);
      end else if (!stall && dreq_n[0] === 1'b0) begin
        dat = nxt;
        drv = 1'b1;
        dack_n[0] = 1'b0;
        repeat (5) @(negedge clk);
        dack_n[0] = 1'b1;
        // Data outlives the release because the device sees it through synchronisers.
        repeat (3) @(negedge clk);
        drv = 1'b0;
        dat = ~nxt;
        nxt = nxt + 8'h01;
        @(negedge clk);
      end
    end
  end
endmodule : hpd_dma_model

// ---- hpd_pkg.sv ----
/*
  Constants, field positions, types and timing figures shared by the host port
  with indirect access and per-timeslot DMA engine.
  Assumes a single 250 MHz clock and frame/timeslot strobes from the device's own timing logic.
*/
package hpd_pkg;
  localparam logic [1:0] OFF_MCS = 2'h0;
  localparam logic [1:0] OFF_LOW = 2'h1;
  localparam logic [1:0] OFF_MODE = 2'h2;
  localparam logic [1:0] OFF_DATA = 2'h3;
  localparam int MCS_SOFT_RST = 0;
  localparam int MCS_DMA_EN = 2;
  localparam int MCS_ROV = 5;
  localparam int MCS_WOV = 6;
  localparam int MODE_A8 = 0;
  localparam int MODE_SP = 4;
  localparam int MODE_INC = 6;
  localparam logic [1:0] SP_CTRL = 2'h0;
  localparam logic [1:0] SP_DM = 2'h1;
  localparam logic [1:0] SP_CML = 2'h2;
  localparam logic [1:0] SP_CMH = 2'h3;
  localparam int MEM_DEPTH = 384;
  localparam int CTRL_DEPTH = 16;
  localparam logic [8:0] CTRL_USED = 9'h00d;
  localparam logic [8:0] LOCAL_BASE = 9'h100;
  localparam int CE_BIT = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MEM_CYCLE_NS = 20;
  localparam int MEM_WAIT_CYC = (MEM_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  typedef enum logic [1:0] {BUS_STROBE, BUS_DSTROBE, BUS_MUX} hpd_bus_e;
  typedef enum logic [1:0] {H_IDLE, H_DIR, H_MEM, H_HOLD} hpd_host_e;
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
  } hpd_wr_s;
endpackage : hpd_pkg

// ---- hpd_port.sv ----
/*
  Host port top (hpd_port) and its DMA write buffer (hpd_fifo).
  Assumes frame_sync and slot_tick are one-cycle pulses on clk from internal timing,
  frame_sync coinciding with the tick that opens timeslot 0; all pins are asynchronous.
*/
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module hpd_fifo #(
  parameter int W = 17,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Full and empty come from the occupancy count, so both sides see honest flags.
  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rp_reg];

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        mem_reg[wp_reg] <= in_data;
        wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : hpd_fifo

////////////////////////////////////////////////////////////////////////////////
module hpd_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic ale,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] a,
  input wire logic [7:0] ad_i,
  output logic [7:0] ad_o,
  output logic ad_oe,
  output logic rdy,
  output logic [1:0] dreq_n,
  input wire logic [1:0] dack_n,
  output logic err,
  input wire logic frame_sync,
  input wire logic slot_tick
);
  // Pin synchronisers: stage one feeds stage two only.
  logic [15:0] s1_reg;
  logic [15:0] s2_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= 16'hf000;
      s2_reg <= 16'hf000;
    end else begin
      s1_reg <= {cs_n, rd_n, wr_n, ale, a, dack_n, ad_i};
      s2_reg <= s1_reg;
    end
  end
  wire p_cs_n = s2_reg[15];
  wire p_rd_n = s2_reg[14];
  wire p_wr_n = s2_reg[13];
  wire p_ale = s2_reg[12];
  wire [1:0] p_a = s2_reg[11:10];
  wire [1:0] p_dack_n = s2_reg[9:8];
  wire [7:0] p_ad = s2_reg[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // Bus style detection: a latch pin toggling while chip select is low means multiplexed for good.
  hpd_pkg::hpd_bus_e bus_reg;
  logic ale_prev_reg;
  logic mux_seen_reg;
  logic [1:0] lat_a_reg;
  logic act_prev_reg;
  wire ale_fall = ale_prev_reg && !p_ale;
  wire is_ds = (bus_reg == hpd_pkg::BUS_DSTROBE);
  // Data-strobe style: read pin strobes, write pin is the direction.
  wire act = !p_cs_n && (is_ds ? !p_rd_n : (!p_rd_n || !p_wr_n));
  wire is_wr = !p_wr_n;
  wire [1:0] addr_now = (bus_reg == hpd_pkg::BUS_MUX) ? lat_a_reg : p_a;
  wire start = act && !act_prev_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      ale_prev_reg <= 1'b1;
      mux_seen_reg <= 1'b0;
      lat_a_reg <= 2'h0;
      act_prev_reg <= 1'b0;
      bus_reg <= hpd_pkg::BUS_STROBE;
    end else begin
      ale_prev_reg <= p_ale;
      act_prev_reg <= act;
      if (p_ale != ale_prev_reg && !p_cs_n) begin
        mux_seen_reg <= 1'b1;
      end
      if (ale_fall) begin
        lat_a_reg <= p_ad[1:0];
      end
      bus_reg <= (mux_seen_reg || (p_ale != ale_prev_reg && !p_cs_n)) ? hpd_pkg::BUS_MUX :
                 (p_ale ? hpd_pkg::BUS_DSTROBE : hpd_pkg::BUS_STROBE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register state and indirect storage, all flip-flops.
  logic [7:0] mcs_reg;
  logic [7:0] low_reg;
  logic [7:0] mode_reg;
  logic [7:0] ctrl_reg [hpd_pkg::CTRL_DEPTH];
  logic [7:0] dm_reg [hpd_pkg::MEM_DEPTH];
  logic [15:0] cm_reg [hpd_pkg::MEM_DEPTH];
  hpd_pkg::hpd_host_e st_reg;
  logic [7:0] wait_reg;
  logic [1:0] acc_a_reg;
  logic acc_wr_reg;
  logic [7:0] acc_d_reg;

  wire [8:0] ptr = {mode_reg[hpd_pkg::MODE_A8], low_reg};
  wire [1:0] space = mode_reg[hpd_pkg::MODE_SP +: 2];
  wire [1:0] inc = mode_reg[hpd_pkg::MODE_INC +: 2];
  wire ptr_ok = (ptr < 9'(hpd_pkg::MEM_DEPTH));
  wire tgt_mem = (addr_now == hpd_pkg::OFF_DATA) && (space != hpd_pkg::SP_CTRL);
  wire fire = (st_reg == hpd_pkg::H_DIR) || (st_reg == hpd_pkg::H_MEM && wait_reg == 8'h00);
  wire fire_wr = fire && acc_wr_reg;
  wire fire_data = fire && (acc_a_reg == hpd_pkg::OFF_DATA);
  wire mem_wr = fire_wr && fire_data && (space != hpd_pkg::SP_CTRL) && ptr_ok;
  // Auto-increment enabled for the direction of this access.
  wire inc_hit = acc_wr_reg ? inc[1] : inc[0];

  // Host access sequencer: direct registers complete at once, memories wait.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= hpd_pkg::H_IDLE;
      wait_reg <= 8'h00;
      acc_a_reg <= 2'h0;
      acc_wr_reg <= 1'b0;
      acc_d_reg <= 8'h00;
    end else begin
      unique case (st_reg)
        hpd_pkg::H_IDLE: begin
          if (start) begin
            acc_a_reg <= addr_now;
            acc_wr_reg <= is_wr;
            acc_d_reg <= p_ad;
            wait_reg <= 8'(hpd_pkg::MEM_WAIT_CYC);
            st_reg <= tgt_mem ? hpd_pkg::H_MEM : hpd_pkg::H_DIR;
          end
        end
        hpd_pkg::H_DIR: st_reg <= hpd_pkg::H_HOLD;
        hpd_pkg::H_MEM: begin
          if (wait_reg == 8'h00) begin
            st_reg <= hpd_pkg::H_HOLD;
          end else begin
            wait_reg <= wait_reg - 8'h01;
          end
        end
        hpd_pkg::H_HOLD: begin
          if (!act) begin
            st_reg <= hpd_pkg::H_IDLE;
          end
        end
      endcase
    end
  end

  // Pointer and mode updates: host writes, then data-window side effects.
  always_ff @(posedge clk) begin
    if (rst) begin
      low_reg <= 8'h00;
      mode_reg <= 8'h00;
    end else if (fire_wr && acc_a_reg == hpd_pkg::OFF_LOW) begin
      low_reg <= acc_d_reg;
    end else if (fire_wr && acc_a_reg == hpd_pkg::OFF_MODE) begin
      mode_reg <= acc_d_reg;
    end else if (fire_data) begin
      if (space == hpd_pkg::SP_CML) begin
        mode_reg[hpd_pkg::MODE_SP +: 2] <= hpd_pkg::SP_CMH;
      end else if (inc_hit && (space == hpd_pkg::SP_DM || space == hpd_pkg::SP_CMH)) begin
        {mode_reg[hpd_pkg::MODE_A8], low_reg} <= ptr + 9'h001;
        if (space == hpd_pkg::SP_CMH) begin
          mode_reg[hpd_pkg::MODE_SP +: 2] <= hpd_pkg::SP_CML;
        end
      end
    end
  end

  // Indirect control space; the soft reset bit clears it but not the memories.
  always_ff @(posedge clk) begin
    if (rst || mcs_reg[hpd_pkg::MCS_SOFT_RST]) begin
      for (int i = 0; i < hpd_pkg::CTRL_DEPTH; i++) begin
        ctrl_reg[i] <= 8'h00;
      end
    end else if (fire_wr && fire_data && space == hpd_pkg::SP_CTRL && ptr < hpd_pkg::CTRL_USED) begin
      ctrl_reg[ptr[3:0]] <= acc_d_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // DMA timing: enable is taken only at a frame start.
  logic [4:0] ts_reg;
  logic dma_on_reg;
  logic first_reg;
  logic [3:0] last_mask_reg;
  logic [4:0] last_ts_reg;
  wire dma_bus_ok = (bus_reg != hpd_pkg::BUS_DSTROBE);
  wire on_new = frame_sync ? (mcs_reg[hpd_pkg::MCS_DMA_EN] && dma_bus_ok) : dma_on_reg;
  wire first_new = frame_sync ? (on_new && !dma_on_reg) : first_reg;
  wire [4:0] ts_new = frame_sync ? 5'h00 : ts_reg + 5'h01;
  logic [3:0] ce_now;

  // Enable bits of the four channels in the opening timeslot, one per stream.
  always_comb begin
    ce_now = 4'h0;
    for (int k = 0; k < 4; k++) begin
      ce_now[k] = cm_reg[9'(hpd_pkg::LOCAL_BASE + {2'h0, ts_new, 2'(k)})][8 + hpd_pkg::CE_BIT];
    end
  end
  // Timeslot 0 is skipped in the first enabled frame.
  wire skip0 = (ts_new == 5'h00) && first_new;
  wire [3:0] rd_req = (slot_tick && on_new && !skip0) ? ce_now : 4'h0;
  wire [3:0] wr_req = (slot_tick && dma_on_reg) ? last_mask_reg : 4'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      ts_reg <= 5'h00;
      dma_on_reg <= 1'b0;
      first_reg <= 1'b0;
      last_mask_reg <= 4'h0;
      last_ts_reg <= 5'h00;
    end else if (slot_tick || frame_sync) begin
      ts_reg <= ts_new;
      dma_on_reg <= on_new;
      first_reg <= first_new;
      last_mask_reg <= rd_req;
      last_ts_reg <= ts_new;
    end
  end

  // Lowest set bit of a burst mask picks the next stream to serve.
  function automatic logic [1:0] hpd_first(input logic [3:0] m);
    hpd_first = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
  endfunction : hpd_first

  //////////////////////////////////////////////////////////////////////////////
  // Read and write bursts; each acknowledge release retires one byte.
  logic [3:0] rd_left_reg;
  logic [4:0] rd_ts_reg;
  logic [3:0] wr_left_reg;
  logic [4:0] wr_ts_reg;
  logic [1:0] dack_prev_reg;
  logic [7:0] held_reg [4];
  logic [3:0] held_v_reg;
  wire [1:0] dack_rel = ~dack_prev_reg & p_dack_n;
  wire [1:0] rd_k = hpd_first(rd_left_reg);
  wire [1:0] wr_k = hpd_first(wr_left_reg);
  wire [8:0] rd_addr = 9'(hpd_pkg::LOCAL_BASE + {2'h0, rd_ts_reg, rd_k});
  wire [8:0] wr_addr = 9'(hpd_pkg::LOCAL_BASE + {2'h0, wr_ts_reg, wr_k});
  wire rd_done = dack_rel[1] && (rd_left_reg != 4'h0);
  wire wr_done = dack_rel[0] && (wr_left_reg != 4'h0);
  wire rd_ovr = (rd_req != 4'h0) && (rd_left_reg & ~(rd_done ? 4'h1 << rd_k : 4'h0)) != 4'h0;
  wire wr_ovr = (wr_req != 4'h0) && (wr_left_reg & ~(wr_done ? 4'h1 << wr_k : 4'h0)) != 4'h0;
  hpd_pkg::hpd_wr_s f_in;
  hpd_pkg::hpd_wr_s f_out;
  wire f_in_ready;
  wire f_out_valid;
  // The memory port is shared; host memory writes stall the drain.
  wire f_out_ready = !mem_wr;
  wire f_push = wr_done && held_v_reg[wr_k];
  assign f_in = '{addr: wr_addr, data: held_reg[wr_k]};

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_left_reg <= 4'h0;
      rd_ts_reg <= 5'h00;
      wr_left_reg <= 4'h0;
      wr_ts_reg <= 5'h00;
      dack_prev_reg <= 2'h3;
      held_v_reg <= 4'h0;
    end else begin
      dack_prev_reg <= p_dack_n;
      if (rd_req != 4'h0) begin
        rd_left_reg <= rd_req;
        rd_ts_reg <= ts_new;
      end else if (rd_done) begin
        rd_left_reg[rd_k] <= 1'b0;
      end
      if (wr_req != 4'h0) begin
        wr_left_reg <= wr_req;
        wr_ts_reg <= last_ts_reg;
      end else if (wr_done) begin
        wr_left_reg[wr_k] <= 1'b0;
      end
      if (wr_done) begin
        held_reg[wr_k] <= p_ad;
        held_v_reg[wr_k] <= 1'b1;
      end
    end
  end

  hpd_fifo #(
    .W($bits(hpd_pkg::hpd_wr_s)),
    .DEPTH(hpd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(f_push),
    .in_ready(f_in_ready),
    .in_data(f_in),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out)
  );

  // Memory writes: host first, buffered DMA bytes when the port is free.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < hpd_pkg::MEM_DEPTH; i++) begin
        dm_reg[i] <= 8'h00;
        cm_reg[i] <= 16'h0000;
      end
    end else if (mem_wr) begin
      if (space == hpd_pkg::SP_DM) begin
        dm_reg[ptr] <= acc_d_reg;
      end else if (space == hpd_pkg::SP_CML) begin
        cm_reg[ptr][7:0] <= acc_d_reg;
      end else begin
        cm_reg[ptr][15:8] <= acc_d_reg;
      end
    end else if (f_out_valid) begin
      dm_reg[f_out.addr] <= f_out.data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Master control/status: overrun events win over a clearing write.
  always_ff @(posedge clk) begin
    if (rst) begin
      mcs_reg <= 8'h00;
    end else begin
      if (fire_wr && acc_a_reg == hpd_pkg::OFF_MCS) begin
        mcs_reg <= acc_d_reg & ~8'h60 | (mcs_reg & acc_d_reg & 8'h60);
      end
      if (rd_ovr) begin
        mcs_reg[hpd_pkg::MCS_ROV] <= 1'b1;
      end
      if (wr_ovr) begin
        mcs_reg[hpd_pkg::MCS_WOV] <= 1'b1;
      end
    end
  end

  // Read-back selection for the host, zero outside the populated locations.
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    unique case (acc_a_reg)
      hpd_pkg::OFF_MCS: rd_val = mcs_reg;
      hpd_pkg::OFF_LOW: rd_val = low_reg;
      hpd_pkg::OFF_MODE: rd_val = mode_reg;
      hpd_pkg::OFF_DATA: begin
        if (space == hpd_pkg::SP_CTRL) begin
          rd_val = (ptr < hpd_pkg::CTRL_USED) ? ctrl_reg[ptr[3:0]] : 8'h00;
        end else if (ptr_ok) begin
          rd_val = (space == hpd_pkg::SP_DM) ? dm_reg[ptr] :
                   (space == hpd_pkg::SP_CML) ? cm_reg[ptr][7:0] : cm_reg[ptr][15:8];
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drivers, all registered.
  wire rd_drive = !p_dack_n[1] && (rd_left_reg != 4'h0);
  wire mem_wait = (st_reg == hpd_pkg::H_MEM) || (st_reg == hpd_pkg::H_IDLE && start && tgt_mem);
  always_ff @(posedge clk) begin
    if (rst) begin
      ad_o <= 8'h00;
      ad_oe <= 1'b0;
      rdy <= 1'b1;
      dreq_n <= 2'h3;
      err <= 1'b0;
    end else begin
      if (fire && !acc_wr_reg) begin
        ad_o <= rd_val;
      end else if (rd_drive) begin
        ad_o <= dm_reg[rd_addr];
      end
      ad_oe <= (act && !is_wr && st_reg == hpd_pkg::H_HOLD) || rd_drive;
      // Strobe styles: high means ready; data-strobe style: low acknowledges.
      rdy <= is_ds ? !(st_reg == hpd_pkg::H_HOLD && act) : !mem_wait;
      dreq_n[1] <= !((rd_req != 4'h0) || (rd_left_reg != 4'h0 && !rd_done) ||
                     (rd_done && (rd_left_reg & ~(4'h1 << rd_k)) != 4'h0));
      // Write requests pause while the buffer is full so no byte is dropped.
      dreq_n[0] <= !(f_in_ready && (wr_req != 4'h0 || wr_left_reg != 4'h0));
      err <= mcs_reg[hpd_pkg::MCS_ROV] || mcs_reg[hpd_pkg::MCS_WOV] || rd_ovr || wr_ovr;
    end
  end
endmodule : hpd_port

// ---- hpd_port_properties.sv ----
/*
  Concurrent checks on the host port pins.
  Assumes one clock domain with synchronous active-high reset; bound into hpd_port.
*/
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module hpd_port_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic ale,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] a,
  input wire logic [7:0] ad_i,
  input wire logic [7:0] ad_o,
  input wire logic ad_oe,
  input wire logic rdy,
  input wire logic [1:0] dreq_n,
  input wire logic [1:0] dack_n,
  input wire logic err,
  input wire logic frame_sync,
  input wire logic slot_tick
);
  logic [4:0] wr_age_reg;
  logic [4:0] wr_age_next;
  logic [2:0] rd_age_reg;
  logic [2:0] rd_age_next;
  logic [2:0] wa_age_reg;
  logic [2:0] wa_age_next;

  // Saturating ages since the last host write strobe and the last acknowledge of each pair.
  assign wr_age_next = (!cs_n && !wr_n) ? 5'h00 : wr_age_reg + {4'h0, wr_age_reg != 5'h1f};
  assign rd_age_next = !dack_n[1] ? 3'h0 : rd_age_reg + {2'h0, rd_age_reg != 3'h7};
  assign wa_age_next = !dack_n[0] ? 3'h0 : wa_age_reg + {2'h0, wa_age_reg != 3'h7};

  always_ff @(posedge clk) begin
    wr_age_reg <= rst ? 5'h1f : wr_age_next;
    rd_age_reg <= rst ? 3'h7 : rd_age_next;
    wa_age_reg <= rst ? 3'h7 : wa_age_next;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_IDLE_AFTER_RESET: assert property ($fell(rst) |-> dreq_n == 2'h3 && rdy && !ad_oe && !err)
    else $error("outputs not idle after reset");
  AST_RDY_ONLY_IN_ACCESS: assert property (cs_n [*6] |-> rdy)
    else $error("rdy low with no access");
  AST_OE_ONLY_WHEN_ASKED: assert property ((cs_n && dack_n[1]) [*5] |-> !ad_oe)
    else $error("bus driven with nobody asking");
  AST_READ_REQ_AT_TICK: assert property ($fell(dreq_n[1]) |-> $past(slot_tick))
    else $error("read request not at timeslot start");
  AST_READ_REQ_HELD: assert property ($rose(dreq_n[1]) |-> rd_age_reg <= 3'h6)
    else $error("read request dropped before burst end");
  AST_WRITE_REQ_HELD: assert property ($rose(dreq_n[0]) |-> wa_age_reg <= 3'h6)
    else $error("write request dropped before burst end");
  AST_DMA_DRIVES_BYTE: assert property ($fell(dack_n[1]) && !dreq_n[1] |-> ##[2:4] ad_oe)
    else $error("read acknowledge without bus drive");
  AST_ERR_AT_TICK: assert property ($rose(err) |-> $past(slot_tick))
    else $error("error raised away from a due request");
  AST_ERR_NEEDS_WRITE: assert property ($fell(err) |-> wr_age_reg < 5'h10)
    else $error("error cleared without a host write");
endmodule : hpd_port_checker

bind hpd_port hpd_port_checker u_hpd_chk (.clk(clk), .rst(rst), .ale(ale), .cs_n(cs_n), .rd_n(rd_n),
  .wr_n(wr_n), .a(a), .ad_i(ad_i), .ad_o(ad_o), .ad_oe(ad_oe), .rdy(rdy), .dreq_n(dreq_n),
  .dack_n(dack_n), .err(err), .frame_sync(frame_sync), .slot_tick(slot_tick));

// ---- hpd_port_tb_top.sv ----
/*
  Self-checking bench for hpd_port: host bus in all three styles, indirect access and DMA.
  Assumes hpd_dma_model as the DMA controller; the bench plays the host and the frame timing.
*/
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module hpd_port_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ale = 1'b1;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [1:0] a = 2'h0;
  logic [7:0] host_ad = 8'h00;
  logic frame_sync = 1'b0;
  logic slot_tick = 1'b0;
  logic tick_en = 1'b0;
  logic stall = 1'b0;
  logic [7:0] ad_i;
  logic [7:0] ad_o;
  logic ad_oe;
  logic rdy;
  logic err;
  logic pdrv;
  logic [7:0] pdat;
  logic [1:0] dreq_n;
  logic [1:0] dack_n;
  logic [31:0] seed = 32'h5fb6;
  logic [7:0] expq[$];
  logic oe_q = 1'b0;
  logic any_req = 1'b0;
  logic [5:0] cyc = 6'h00;
  logic [4:0] slot = 5'h1f;
  int fcnt = 0;
  int style = 1;
  int miscompares = 0;
  int n_checks = 0;

  // Shared bus level: device, then DMA controller, then host (inverted last value when idle).
  assign ad_i = ad_oe ? ad_o : (pdrv ? pdat : host_ad);

  always #2 clk = ~clk;

  hpd_port dut (.clk(clk), .rst(rst), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a(a),
    .ad_i(ad_i), .ad_o(ad_o), .ad_oe(ad_oe), .rdy(rdy), .dreq_n(dreq_n), .dack_n(dack_n),
    .err(err), .frame_sync(frame_sync), .slot_tick(slot_tick));

  hpd_dma_model u_dma (.clk(clk), .dreq_n(dreq_n), .stall(stall), .dack_n(dack_n), .dat(pdat),
    .drv(pdrv));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic check1(input string what, input logic exp, input logic got);
    check8(what, {7'h00, exp}, {7'h00, got});
  endtask : check1

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic do_reset();
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask : do_reset

  // One host cycle; outside data-strobe style, slow 0 expects no wait state, 1 expects one, 2 leaves it unchecked.
  task automatic bus(input bit wr, input logic [1:0] ra, input logic [7:0] d, input int slow);
    int n;
    bit waited;
    waited = 0;
    if (!wr) expq.push_back(d);
    @(negedge clk);
    cs_n = 1'b0;
    a = ra;
    if (style == 2) begin
      a = ra ^ {wr, 1'b0};
      host_ad = {6'h00, ra};
      ale = 1'b1;
      repeat (3) @(negedge clk);
      ale = 1'b0;
      repeat (3) @(negedge clk);
    end
    host_ad = wr ? d : ~host_ad;
    if (style == 1) begin
      wr_n = !wr;
      rd_n = 1'b0;
    end else if (wr) wr_n = 1'b0;
    else rd_n = 1'b0;
    for (n = 0; n < 60; n++) begin
      @(negedge clk);
      if (rdy === 1'b0) waited = 1;
      if (style == 1 && rdy === 1'b0) break;
      if (style != 1 && n >= 5 && rdy === 1'b1 && (wr || ad_oe === 1'b1)) break;
    end
    if (n == 60) check1("bus completion", 1'b1, 1'b0);
    if (style != 1 && slow < 2) check1("wait state", slow[0], waited);
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    host_ad = ~host_ad;
    repeat (5) @(negedge clk);
  endtask : bus

  task automatic setp(input logic [7:0] lo, input logic [7:0] md);
    bus(1, hpd_pkg::OFF_LOW, lo, 0);
    bus(1, hpd_pkg::OFF_MODE, md, 0);
  endtask : setp

  task automatic wait_slot(input int f, input int s);
    int n;
    for (n = 0; n < 5000; n++) begin
      @(posedge clk);
      if (fcnt == f && slot == 5'(s)) break;
    end
    @(negedge clk);
    if (n == 5000) check1("frame position reached", 1'b1, 1'b0);
  endtask : wait_slot

  ////////////////////////////////////////////////////////////////////////////////
  // Frame timing: 40 cycles per timeslot, 32 timeslots, frame pulse on the slot 0 tick.
  always @(negedge clk) begin
    slot_tick <= 1'b0;
    frame_sync <= 1'b0;
    if (tick_en) begin
      cyc <= (cyc == 6'h27) ? 6'h00 : cyc + 6'h01;
      if (cyc == 6'h27) begin
        slot <= slot + 5'h01;
        slot_tick <= 1'b1;
        frame_sync <= (slot == 5'h1f);
        if (slot == 5'h1f) fcnt <= fcnt + 1;
      end
    end
  end

  // Every new drive of the bus by the device is one result, matched to the oldest note.
  always @(negedge clk) begin
    if (dreq_n !== 2'h3) any_req = 1'b1;
    if (ad_oe === 1'b1 && oe_q !== 1'b1) begin
      if (expq.size() == 0) check1("unexpected bus drive", 1'b0, 1'b1);
      else check8("bus data", expq.pop_front(), ad_o);
    end
    oe_q = ad_oe;
  end

  initial begin
    repeat (30000) @(posedge clk);
    check1("watchdog", 1'b1, 1'b0);
    stop_test();
  end

  initial begin : main
    logic [7:0] r;
    logic [7:0] c[4];
    int m;
    do_reset();
    r = rnd();
    bus(1, hpd_pkg::OFF_LOW, r, 2);
    bus(0, hpd_pkg::OFF_LOW, r, 2);
    $display("test data strobe done");
    ale = 1'b0;
    style = 0;
    do_reset();
    check1("rdy", 1'b1, rdy);
    check1("err", 1'b0, err);
    check8("dreq_n", 8'h03, {6'h00, dreq_n});
    bus(0, hpd_pkg::OFF_MCS, 8'h00, 0);
    for (m = 1; m < 3; m++) begin
      r = rnd() & 8'hf1;
      bus(1, 2'(m), r, 0);
      bus(0, 2'(m), r, 0);
    end
    // Each increment mode writes two bytes, read back with increment on read.
    for (m = 0; m < 4; m++) begin
      c[0] = rnd();
      c[1] = rnd();
      setp(8'h40 + 8'(m * 4), {2'(m), hpd_pkg::SP_DM, 4'h0});
      bus(1, hpd_pkg::OFF_DATA, c[0], 1);
      bus(1, hpd_pkg::OFF_DATA, c[1], 1);
      setp(8'h40 + 8'(m * 4), {2'h1, hpd_pkg::SP_DM, 4'h0});
      bus(0, hpd_pkg::OFF_DATA, (m >= 2) ? c[0] : c[1], 1);
      bus(0, hpd_pkg::OFF_DATA, (m >= 2) ? c[1] : 8'h00, 1);
    end
    $display("test data memory done");
    for (m = 0; m < 4; m++) c[m] = rnd();
    setp(8'h10, {2'h2, hpd_pkg::SP_CML, 4'h0});
    for (m = 0; m < 4; m++) bus(1, hpd_pkg::OFF_DATA, c[m], 1);
    setp(8'h10, {2'h1, hpd_pkg::SP_CML, 4'h0});
    for (m = 0; m < 4; m++) bus(0, hpd_pkg::OFF_DATA, c[m], 1);
    setp(8'h30, {2'h0, hpd_pkg::SP_CML, 4'h0});
    for (m = 0; m < 3; m++) bus(1, hpd_pkg::OFF_DATA, c[m], 1);
    setp(8'h30, {2'h0, hpd_pkg::SP_CML, 4'h0});
    bus(0, hpd_pkg::OFF_DATA, c[0], 1);
    bus(0, hpd_pkg::OFF_DATA, c[2], 1);
    setp(8'h01, {2'h3, hpd_pkg::SP_CTRL, 4'h0});
    bus(1, hpd_pkg::OFF_DATA, c[0], 2);
    bus(1, hpd_pkg::OFF_DATA, c[1], 2);
    setp(8'h02, {2'h0, hpd_pkg::SP_CTRL, 4'h0});
    bus(0, hpd_pkg::OFF_DATA, 8'h00, 2);
    setp(8'h90, {2'h0, hpd_pkg::SP_DM, 4'h1});
    bus(1, hpd_pkg::OFF_DATA, c[3], 2);
    bus(0, hpd_pkg::OFF_DATA, 8'h00, 2);
    $display("test connection memory done");
    // Timeslots 2 and 4 of stream 0 enabled; the controller's first write byte is a0.
    c[0] = rnd();
    for (m = 0; m < 2; m++) begin
      setp(8'h08 + 8'(m * 8), {2'h0, hpd_pkg::SP_CMH, 4'h1});
      bus(1, hpd_pkg::OFF_DATA, 8'h08, 1);
      setp(8'h08 + 8'(m * 8), {2'h0, hpd_pkg::SP_DM, 4'h1});
      bus(1, hpd_pkg::OFF_DATA, c[0], 1);
    end
    tick_en = 1'b1;
    wait_slot(1, 1);
    any_req = 1'b0;
    expq.push_back(c[0]);
    expq.push_back(c[0]);
    bus(1, hpd_pkg::OFF_MCS, 8'h04, 0);
    wait_slot(2, 0);
    check1("request before frame start", 1'b0, any_req);
    wait_slot(2, 10);
    stall = 1'b1;
    wait_slot(3, 6);
    tick_en = 1'b0;
    check1("err", 1'b1, err);
    expq.push_back(8'ha0);
    stall = 1'b0;
    for (m = 0; m < 200 && dreq_n !== 2'h3; m++) @(negedge clk);
    check8("dreq_n", 8'h03, {6'h00, dreq_n});
    bus(0, hpd_pkg::OFF_MCS, 8'(32'h4 | (1 << hpd_pkg::MCS_ROV) | (1 << hpd_pkg::MCS_WOV)), 0);
    bus(1, hpd_pkg::OFF_MCS, 8'h00, 0);
    bus(0, hpd_pkg::OFF_MCS, 8'h00, 0);
    check1("err", 1'b0, err);
    setp(8'h10, {2'h0, hpd_pkg::SP_DM, 4'h1});
    bus(0, hpd_pkg::OFF_DATA, 8'ha1, 1);
    $display("test dma done");
    style = 2;
    do_reset();
    r = rnd();
    bus(1, hpd_pkg::OFF_LOW, r, 0);
    bus(0, hpd_pkg::OFF_LOW, r, 0);
    $display("test multiplexed done");
    stop_test();
  end
endmodule : hpd_port_tb_top
